// ---- verilog/wrs_sequencer.sv ----
`timescale 1ns/100ps
module wrs_sequencer
  import wrs_pkg::*;
#(
  parameter int STRETCH = STRETCH_CYCLES,
  parameter int REL_WAIT = RELEASE_WAIT_CYCLES,
  parameter int HOLDOFF = CS_HOLDOFF_CYCLES
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_warm_reset_line_n,
  input wire logic [7:0] i_periph_data_bus,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_data,
  input wire logic i_cpu_data_oe,
  input wire logic i_cpu_mem_ctrl_n,
  input wire logic i_cpu_first_sel_n,
  output logic o_warm_reset_line_n,
  output logic o_warm_reset_line_oe,
  output logic [7:0] o_periph_data_bus,
  output logic o_periph_data_bus_oe,
  output logic [7:0] o_periph_data_in,
  output logic [15:0] o_periph_address_bus,
  output logic o_periph_address_bus_oe,
  output logic o_mem_ctrl_n,
  output logic o_first_periph_select_n,
  output logic o_soft_reset_exc,
  output logic o_in_warm_reset
);
  import wrs_pkg::*;

  localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH - 1);
  localparam logic [CNT_W-1:0] REL_LAST = CNT_W'(REL_WAIT - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLDOFF - 1);

  wrs_reg_type r;
  wrs_reg_type next_r;
  logic line_low;

  // ****************************************
  // Sequencer
  // ****************************************
  // Only the second stage is read; own drive is masked so release is never missed
  assign line_low = ~r.sync2 & ~r.line_drive;

  always_comb
  begin
    next_r = r;
    next_r.sync1 = i_warm_reset_line_n;
    next_r.sync2 = r.sync1;
    next_r.soft_rst = 1'b0;
    next_r.bus.addr_out = i_cpu_addr;
    next_r.bus.addr_oe = 1'b1;
    next_r.bus.data_out = i_cpu_data;
    case (r.state)
      ST_RUN:
      begin
        next_r.bus.data_oe = i_cpu_data_oe;
        next_r.bus.mem_ctrl_en = 1'b1;
        next_r.bus.first_sel_en = 1'b1;
        if (~r.sync2)
        begin
          next_r.state = ST_STRETCH;
          next_r.cnt = CNT_ZERO;
          next_r.line_drive = 1'b1;
          next_r.bus.data_oe = 1'b0;
          next_r.bus.mem_ctrl_en = 1'b0;
          next_r.bus.first_sel_en = 1'b0;
        end
      end
      ST_STRETCH:
      begin
        next_r.cnt = r.cnt + CNT_ONE;
        if (r.cnt == STRETCH_LAST)
        begin
          next_r.line_drive = 1'b0;
          next_r.state = ST_WAIT_REL;
          next_r.cnt = CNT_ZERO;
        end
      end
      ST_WAIT_REL:
      begin
        // Release only counts once the wait window has passed
        // A line still held low after the window keeps the block waiting with no limit
        if (r.cnt != REL_LAST)
        begin
          next_r.cnt = r.cnt + CNT_ONE;
        end
        else if (r.sync2 && !line_low)
        begin
          next_r.state = ST_HOLDOFF;
          next_r.cnt = CNT_ZERO;
          next_r.bus.data_oe = i_cpu_data_oe;
          next_r.bus.mem_ctrl_en = 1'b1;
          next_r.soft_rst = 1'b1;
        end
      end
      ST_HOLDOFF:
      begin
        next_r.bus.data_oe = i_cpu_data_oe;
        next_r.cnt = r.cnt + CNT_ONE;
        if (r.cnt == HOLD_LAST)
        begin
          next_r.state = ST_RUN;
          next_r.bus.first_sel_en = 1'b1;
        end
        if (~r.sync2)
        begin
          next_r.state = ST_STRETCH;
          next_r.cnt = CNT_ZERO;
          next_r.line_drive = 1'b1;
          next_r.bus.data_oe = 1'b0;
          next_r.bus.mem_ctrl_en = 1'b0;
          next_r.bus.first_sel_en = 1'b0;
        end
      end
      default:
      begin
        next_r.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      r.sync1 <= 1'b1;
      r.sync2 <= 1'b1;
      r.state <= ST_RUN;
      r.cnt <= CNT_ZERO;
      r.line_drive <= 1'b0;
      r.soft_rst <= 1'b0;
      r.bus <= BUS_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  assign o_warm_reset_line_n = 1'b0;
  assign o_warm_reset_line_oe = r.line_drive;
  assign o_periph_data_bus = r.bus.data_out;
  assign o_periph_data_bus_oe = r.bus.data_oe;
  // Data pins are not timed to i_mclk, so they pass a two-stage chain as well
  wrs_sync #(
    .WIDTH($bits(i_periph_data_bus))
  ) u_data_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_async(i_periph_data_bus),
    .o_sync(o_periph_data_in)
  );
  assign o_periph_address_bus = r.bus.addr_out;
  assign o_periph_address_bus_oe = r.bus.addr_oe;
  assign o_mem_ctrl_n = i_cpu_mem_ctrl_n | ~r.bus.mem_ctrl_en;
  assign o_first_periph_select_n = i_cpu_first_sel_n | ~r.bus.first_sel_en;
  assign o_soft_reset_exc = r.soft_rst;
  assign o_in_warm_reset = (r.state != ST_RUN);

endmodule

// ****************************************
// Two-stage synchroniser
// ****************************************
// Only the second stage leaves the module; the first may go metastable
module wrs_sync
#(
  parameter int WIDTH = 8
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  import wrs_pkg::*;

  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } wrs_sync_type;

  wrs_sync_type r;
  wrs_sync_type next_r;

  always_comb
  begin
    next_r = r;
    next_r.stage1 = i_async;
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_sync = r.stage2;

endmodule

// ---- include/wrs_pkg.sv ----
package wrs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 20;
  localparam int STRETCH_CYCLES = 4000;
  localparam int RELEASE_WAIT_CYCLES = 4000;
  localparam int CS_HOLDOFF_CYCLES = 16;
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

  // ****************************************
  // Pin groups
  // ****************************************
  typedef struct packed
  {
    logic [7:0] data_out;
    logic data_oe;
    logic [15:0] addr_out;
    logic addr_oe;
    logic mem_ctrl_en;
    logic first_sel_en;
  } wrs_bus_type;

  typedef enum logic [2:0]
  {
    ST_RUN = 3'b000,
    ST_STRETCH = 3'b001,
    ST_WAIT_REL = 3'b010,
    ST_HOLDOFF = 3'b011
  } wrs_state_type;

  typedef struct packed
  {
    logic sync1;
    logic sync2;
    wrs_state_type state;
    logic [CNT_W-1:0] cnt;
    logic line_drive;
    logic soft_rst;
    wrs_bus_type bus;
  } wrs_reg_type;

  localparam wrs_bus_type BUS_RESET = '{data_out: 8'h00, data_oe: 1'b0, addr_out: 16'h0000,
                                        addr_oe: 1'b1, mem_ctrl_en: 1'b0, first_sel_en: 1'b0};

endpackage

// ---- testbench/wrs_sequencer_checker.sv ----
`timescale 1ns/100ps
module wrs_sequencer_checker #(
  parameter int STRETCH = 4000,
  parameter int REL_WAIT = 4000,
  parameter int HOLDOFF = 16
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_warm_reset_line_n,
  input wire logic o_warm_reset_line_oe,
  input wire logic o_periph_data_bus_oe,
  input wire logic o_mem_ctrl_n,
  input wire logic o_first_periph_select_n,
  input wire logic o_soft_reset_exc,
  input wire logic o_in_warm_reset
);
  localparam int S1 = STRETCH - 1;
  localparam int W1 = REL_WAIT - 1;
  localparam int H1 = HOLDOFF - 1;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  a_entry_seen: assert property ((!o_in_warm_reset && i_warm_reset_line_n) ##1 (!i_warm_reset_line_n)[*3]
    |-> ##[0:2] o_warm_reset_line_oe) else $error("entry not taken");
  a_data_float: assert property (o_warm_reset_line_oe |-> !o_periph_data_bus_oe) else $error("data driven");
  a_mem_negated: assert property (o_warm_reset_line_oe |-> o_mem_ctrl_n) else $error("mem ctrl active");
  a_drive_len: assert property ($rose(o_warm_reset_line_oe) |-> ##S1 o_warm_reset_line_oe ##1 !o_warm_reset_line_oe)
    else $error("stretch length wrong");
  a_release_wait: assert property ($fell(o_warm_reset_line_oe) |-> not (##[0:W1] o_soft_reset_exc))
    else $error("release taken early");
  a_exc_cause: assert property (o_soft_reset_exc |-> $past(o_in_warm_reset) && !o_warm_reset_line_oe)
    else $error("stray exception");
  a_select_off: assert property (o_in_warm_reset |-> o_first_periph_select_n) else $error("select early");
  a_holdoff_len: assert property (o_soft_reset_exc |-> ##H1 o_in_warm_reset ##1 !o_in_warm_reset)
    else $error("holdoff length wrong");
  cover property ($rose(o_warm_reset_line_oe));
  cover property (o_soft_reset_exc);
  cover property ($fell(o_in_warm_reset));
endmodule
bind wrs_sequencer wrs_sequencer_checker #(.STRETCH(STRETCH), .REL_WAIT(REL_WAIT), .HOLDOFF(HOLDOFF)) u_chk (.*);

// ---- testbench/wrs_ext_agent.sv ----
`timescale 1ns/100ps
module wrs_ext_agent (
  input wire logic i_mclk,
  input wire logic i_pull,
  input wire logic i_dev_oe,
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_data_oe,
  output logic o_line_n,
  output logic [7:0] o_data
);
  logic [7:0] pat = 8'h00;
  always @(posedge i_mclk) pat <= pat + 8'h01;
  // Wired-AND with pull-up: high only once both parties let go
  assign o_line_n = !(i_pull || i_dev_oe);
  // Floated bus churns so a stale value never passes
  assign o_data = i_dev_data_oe ? i_dev_data : pat;
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import wrs_pkg::*;
  logic i_mclk = 0, i_rst_b = 0, i_cpu_data_oe = 0, i_cpu_mem_ctrl_n = 1, i_cpu_first_sel_n = 1, pull = 0;
  logic i_warm_reset_line_n, o_warm_reset_line_n, o_warm_reset_line_oe, o_periph_data_bus_oe;
  logic o_periph_address_bus_oe, o_mem_ctrl_n, o_first_periph_select_n, o_soft_reset_exc, o_in_warm_reset;
  logic [15:0] i_cpu_addr = 16'h0000, o_periph_address_bus;
  logic [7:0] i_cpu_data = 8'h00, i_periph_data_bus, o_periph_data_bus, o_periph_data_in;
  int errors = 0, checks = 0, cyc = 0, k, hold;
  always #25 i_mclk = ~i_mclk;
  // Two-cycle history of the data pins, as the input chain should deliver them
  logic [7:0] din_d1, din_d2;
  always @(posedge i_mclk) {din_d2, din_d1} <= {din_d1, i_periph_data_bus};
  wrs_sequencer #(.STRETCH(20), .REL_WAIT(20), .HOLDOFF(4)) u_wrs_sequencer (.*);
  wrs_ext_agent u_wrs_ext_agent (.i_mclk(i_mclk), .i_pull(pull), .i_dev_oe(o_warm_reset_line_oe),
    .i_dev_data(o_periph_data_bus), .i_dev_data_oe(o_periph_data_bus_oe), .o_line_n(i_warm_reset_line_n),
    .o_data(i_periph_data_bus));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Core traffic outside reset: address registered, controls pass through
  task automatic traffic();
    @(negedge i_mclk);
    cmp(o_periph_address_bus, i_cpu_addr);
    cmp(o_mem_ctrl_n, i_cpu_mem_ctrl_n);
    cmp({o_periph_data_bus_oe, o_periph_data_bus}, {i_cpu_data_oe, i_cpu_data});
    cmp(o_first_periph_select_n, i_cpu_first_sel_n);
    if (cyc > 12)
      cmp(o_periph_data_in, din_d2);
    {i_cpu_addr, i_cpu_data, i_cpu_mem_ctrl_n, i_cpu_first_sel_n} = 26'($urandom);
  endtask
  // Release is taken once the 20-cycle window has run out and the line has crossed two sync stages
  function automatic int exp_release(input int h);
    return (h + 3 > 20) ? h + 3 : 20;
  endfunction
  task automatic warm();
    {i_cpu_mem_ctrl_n, i_cpu_first_sel_n, i_cpu_data_oe, pull} = 4'h3;
    for (k = 0; !o_warm_reset_line_oe && k < 10; k++) @(negedge i_mclk);
    cmp(16'(k), 16'h0003);
    cmp({o_periph_data_bus_oe, o_mem_ctrl_n, o_periph_address_bus_oe}, 3'h3);
    cmp({o_warm_reset_line_n, o_first_periph_select_n}, 2'h1);
    for (k = 0; o_warm_reset_line_oe && k < 100; k++) @(negedge i_mclk);
    cmp(16'(k), 16'h0014);
    for (k = 0; !o_soft_reset_exc && k < 200; k++)
    begin
      if (k == hold)
        pull = 0;
      @(negedge i_mclk);
    end
    cmp(16'(k >= 20 && k > hold && o_periph_data_bus_oe), 16'h0001);
    cmp(16'(k), 16'(exp_release(hold)));
    cmp(o_first_periph_select_n, 1'b1);
    @(negedge i_mclk);
    cmp(o_soft_reset_exc, 1'b0);
    for (k = 1; o_in_warm_reset && k < 50; k++) @(negedge i_mclk);
    cmp(16'(k), 16'h0004);
    cmp(o_first_periph_select_n, 1'b0);
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(32'h1e6ad50a));
    repeat (10) @(negedge i_mclk);
    i_rst_b = 1;
    for (int t = 0; t < 4; t++)
    begin
      repeat (30) traffic();
      // Corner cases first: instant release, release long after the window
      hold = (t == 0) ? 0 : (t == 1) ? 45 : $urandom_range(30);
      warm();
    end
    conclude();
  end
endmodule
